// ===== src/rcs_regs.svh
// constants for the reset cause and register reset-state block
// Notes on behaviour
// R1: a power-on reset sets the active-low time-out flag, so cleared time-out with cleared power-on never shows.
// R2: a power-on reset sets the active-low power-down flag, so cleared power-down with cleared power-on never shows.
// R3: a master-clear while running zeroes the program counter and the upper three status bits and keeps both status flags and the power-control flags.
// R4: a master-clear during sleep zeroes the program counter and upper status bits, sets time-out and clears power-down.
// R5: an interrupt wake-up advances the program counter, sets time-out, clears power-down and keeps the other status bits.
// R6: an interrupt wake-up with the global interrupt enable set loads the interrupt vector instead of the next address.
// R7: a watchdog reset clears time-out, sets power-down and zeroes the counter; a watchdog wake-up clears both and advances the counter.
// R8: power-on clears only the power-on flag, brown-out clears only the brown-out flag, every other cause keeps both.
// R9: power-on and brown-out load identical reset values: option and direction all ones, interrupt control zero but its last bit, page latch zero.
// R10: a wake-up keeps register contents except the time-out and power-down flags and the interrupt flag bits that record the wake cause.
// R11: software keeps reserved bits cleared; the block clears them on reset.
// R12: software sets the power-on flag after a power-on reset so later resets read as other causes.
// R13: the brown-out flag is unpredictable while the brown-out circuit is disabled.
// R14: cause and all reset values are taken in the clock cycle in which the reset is released.
// R15: among simultaneous requests power-on wins, then brown-out, then watchdog, then master-clear.
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH
`define RCS_ST_BANK_HI 7
`define RCS_ST_BANK_LO 5
`define RCS_ST_TO 4
`define RCS_ST_PD 3
`define RCS_POWER_CONTROL_REG_POR 1
`define RCS_POWER_CONTROL_REG_BOR 0
`define RCS_GIE_BIT 7
`define RCS_PC_RESET 13'h0000
`define RCS_PC_VECTOR 13'h0004
`define RCS_PC_STEP 13'h0001
`define RCS_BANK_RESET 3'h0
`define RCS_STATUS_RESET 8'h18
`define RCS_POWER_CONTROL_REG_RESET 2'h1
`define RCS_OPTION_RESET 8'hFF
`define RCS_DIRA_RESET 6'h3F
`define RCS_IRQ_CONTROL_REG_KEEP 8'h01
`define RCS_PAGE_RESET 5'h00
`define RCS_PIRA_RESET 8'h00
`define RCS_PIRB_RESET 8'h00
`endif

// ===== src/rcs_pkg.sv
// types for the reset cause and register reset-state block
package rcs_pkg;
   typedef enum logic [2:0] {
      rcs_cause_none = 3'h0,
      rcs_cause_por = 3'h1,
      rcs_cause_bor = 3'h2,
      rcs_cause_wdt_reset = 3'h3,
      rcs_cause_master_clear_pin_n_run = 3'h4,
      rcs_cause_master_clear_pin_n_sleep = 3'h5,
      rcs_cause_wdt_wake = 3'h6,
      rcs_cause_irq_wake = 3'h7
   } rcs_cause_type;
   typedef enum logic [1:0] {
      rcs_st_run = 2'h0,
      rcs_st_hold = 2'h1
   } rcs_state_type;
   typedef enum logic [2:0] {
      rcs_sel_status = 3'h0,
      rcs_sel_power_control_reg = 3'h1,
      rcs_sel_irq_control_reg = 3'h2,
      rcs_sel_pira = 3'h3,
      rcs_sel_pirb = 3'h4,
      rcs_sel_option = 3'h5,
      rcs_sel_dira = 3'h6,
      rcs_sel_page = 3'h7
   } rcs_sel_type;
endpackage

// ===== src/rcs_pc_sel.sv
// program counter start point chosen from the applied cause
`timescale 1ns/100ps
`include "rcs_regs.svh"
module rcs_pc_sel #(
   parameter int PC_WIDTH = 13
) (
   input wire rcs_pkg::rcs_cause_type i_cause,
   input wire logic [PC_WIDTH-1:0] i_pc,
   input wire logic i_global_irq_enable,
   output logic [PC_WIDTH-1:0] o_next_pc,
   output logic o_load
);
   wire logic is_wake;
   wire logic [PC_WIDTH-1:0] step_pc;
   assign is_wake = (i_cause == rcs_pkg::rcs_cause_wdt_wake) ||
                    (i_cause == rcs_pkg::rcs_cause_irq_wake);
   assign step_pc = PC_WIDTH'(i_pc + PC_WIDTH'(`RCS_PC_STEP)); // R5 R7
   assign o_load = (i_cause != rcs_pkg::rcs_cause_none);
   always_comb begin
      if (!is_wake) begin
         o_next_pc = PC_WIDTH'(`RCS_PC_RESET); // R3 R4 R7
      end else if ((i_cause == rcs_pkg::rcs_cause_irq_wake) && i_global_irq_enable) begin
         o_next_pc = PC_WIDTH'(`RCS_PC_VECTOR); // R6
      end else begin
         o_next_pc = step_pc;
      end
   end
endmodule

// ===== src/rcs_top.sv
// reset cause recording and special register reset-state logic
`timescale 1ns/100ps
`include "rcs_regs.svh"
module rcs_top #(
   parameter int PC_WIDTH = 13
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_por_req,
   input wire logic i_bor_req,
   input wire logic i_brownout_circuit_enable,
   input wire logic i_master_clear_pin_n,
   input wire logic i_watchdog_timeout,
   input wire logic i_sleeping,
   input wire logic i_wake_irq,
   input wire logic [7:0] i_wake_irq_flags,
   input wire logic [7:0] i_wake_periph_flags_a,
   input wire logic [7:0] i_wake_periph_flags_b,
   input wire logic [PC_WIDTH-1:0] i_pc,
   input wire logic i_sw_we,
   input wire rcs_pkg::rcs_sel_type i_sw_sel,
   input wire logic [7:0] i_sw_data,
   output logic [7:0] o_status,
   output logic [1:0] o_power_control_reg,
   output logic [7:0] o_irq_control_reg,
   output logic [7:0] o_periph_irq_flags_a,
   output logic [7:0] o_periph_irq_flags_b,
   output logic [7:0] o_option_reg,
   output logic [5:0] o_direction_reg_a,
   output logic [4:0] o_program_page_latch,
   output logic [PC_WIDTH-1:0] o_pc,
   output logic o_pc_load,
   output rcs_pkg::rcs_cause_type o_cause,
   output logic o_cause_valid,
   output logic o_in_reset
);
   ////////////////////////////////////////////////////////////////////////////////
   // cause priority
   function automatic logic [2:0] rank(input rcs_pkg::rcs_cause_type c);
      logic [2:0] r;
      r = 3'h0;
      unique case (c)
         rcs_pkg::rcs_cause_por: r = 3'h4;
         rcs_pkg::rcs_cause_bor: r = 3'h3;
         rcs_pkg::rcs_cause_wdt_reset: r = 3'h2;
         rcs_pkg::rcs_cause_master_clear_pin_n_run, rcs_pkg::rcs_cause_master_clear_pin_n_sleep: r = 3'h1;
         rcs_pkg::rcs_cause_none, rcs_pkg::rcs_cause_wdt_wake,
         rcs_pkg::rcs_cause_irq_wake: r = 3'h0;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] pick(input logic sel, input logic [7:0] d,
                                       input logic [7:0] q);
      return sel ? d : q;
   endfunction

   rcs_pkg::rcs_state_type state;
   rcs_pkg::rcs_state_type next_state;
   rcs_pkg::rcs_cause_type held_cause;
   rcs_pkg::rcs_cause_type next_held_cause;
   rcs_pkg::rcs_cause_type req_cause;
   rcs_pkg::rcs_cause_type apply_cause;

   wire logic bor_req;
   wire logic master_clear_pin_n_req;
   wire logic wdt_reset_req;
   wire logic any_reset;
   wire logic wdt_wake;
   wire logic irq_wake;

   // disabled brown-out circuit is not trusted, its request is dropped
   assign bor_req = i_bor_req && i_brownout_circuit_enable; // R13
   assign master_clear_pin_n_req = !i_master_clear_pin_n;
   // a watchdog time-out while asleep wakes the core rather than resetting it
   assign wdt_reset_req = i_watchdog_timeout && !i_sleeping;
   assign any_reset = i_por_req || bor_req || wdt_reset_req || master_clear_pin_n_req;
   assign wdt_wake = i_watchdog_timeout && i_sleeping;
   assign irq_wake = i_wake_irq && i_sleeping;

   always_comb begin
      if (i_por_req) begin
         req_cause = rcs_pkg::rcs_cause_por; // R15
      end else if (bor_req) begin
         req_cause = rcs_pkg::rcs_cause_bor; // R15
      end else if (wdt_reset_req) begin
         req_cause = rcs_pkg::rcs_cause_wdt_reset; // R15
      end else if (master_clear_pin_n_req) begin
         req_cause = i_sleeping ? rcs_pkg::rcs_cause_master_clear_pin_n_sleep : rcs_pkg::rcs_cause_master_clear_pin_n_run;
      end else begin
         req_cause = rcs_pkg::rcs_cause_none;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing: hold while any request stands, apply on release
   always_comb begin
      next_state = state;
      next_held_cause = held_cause;
      apply_cause = rcs_pkg::rcs_cause_none;
      unique case (state)
         rcs_pkg::rcs_st_run: begin
            if (any_reset) begin
               next_state = rcs_pkg::rcs_st_hold;
               next_held_cause = req_cause;
            end else if (wdt_wake) begin
               apply_cause = rcs_pkg::rcs_cause_wdt_wake;
            end else if (irq_wake) begin
               apply_cause = rcs_pkg::rcs_cause_irq_wake;
            end
         end
         rcs_pkg::rcs_st_hold: begin
            // equal rank keeps the first sleep or run view of master-clear
            if (rank(req_cause) > rank(held_cause)) begin
               next_held_cause = req_cause; // R15
            end
            if (!any_reset) begin
               next_state = rcs_pkg::rcs_st_run;
               apply_cause = held_cause; // R14
            end
         end
         default: begin
            next_state = rcs_pkg::rcs_st_run;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= rcs_pkg::rcs_st_run;
         held_cause <= rcs_pkg::rcs_cause_none;
      end else begin
         state <= next_state;
         held_cause <= next_held_cause;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // cause decode
   wire logic is_por;
   wire logic is_bor;
   wire logic is_wdt_reset;
   wire logic is_master_clear_pin_n_run;
   wire logic is_master_clear_pin_n_sleep;
   wire logic is_full_reset;
   wire logic is_wake;
   assign is_por = (apply_cause == rcs_pkg::rcs_cause_por);
   assign is_bor = (apply_cause == rcs_pkg::rcs_cause_bor);
   assign is_wdt_reset = (apply_cause == rcs_pkg::rcs_cause_wdt_reset);
   assign is_master_clear_pin_n_run = (apply_cause == rcs_pkg::rcs_cause_master_clear_pin_n_run);
   assign is_master_clear_pin_n_sleep = (apply_cause == rcs_pkg::rcs_cause_master_clear_pin_n_sleep);
   assign is_full_reset = is_por || is_bor || is_wdt_reset || is_master_clear_pin_n_run || is_master_clear_pin_n_sleep;
   assign is_wake = (apply_cause == rcs_pkg::rcs_cause_wdt_wake) ||
                    (apply_cause == rcs_pkg::rcs_cause_irq_wake);

   ////////////////////////////////////////////////////////////////////////////////
   // software write path; hardware updates below win over a same-cycle write
   wire logic [7:0] base_status;
   wire logic [7:0] base_power_control_reg;
   wire logic [7:0] base_irq_control_reg;
   wire logic [7:0] base_pira;
   wire logic [7:0] base_pirb;
   wire logic [7:0] base_option;
   wire logic [7:0] base_dira;
   wire logic [7:0] base_page;
   assign base_status = pick(i_sw_we && (i_sw_sel == rcs_pkg::rcs_sel_status), i_sw_data,
                             o_status);
   // software setting the power-on flag marks later resets as other causes
   assign base_power_control_reg = pick(i_sw_we && (i_sw_sel == rcs_pkg::rcs_sel_power_control_reg), i_sw_data,
                           {6'h00, o_power_control_reg}); // R12
   assign base_irq_control_reg = pick(i_sw_we && (i_sw_sel == rcs_pkg::rcs_sel_irq_control_reg), i_sw_data,
                             o_irq_control_reg);
   assign base_pira = pick(i_sw_we && (i_sw_sel == rcs_pkg::rcs_sel_pira), i_sw_data,
                           o_periph_irq_flags_a);
   assign base_pirb = pick(i_sw_we && (i_sw_sel == rcs_pkg::rcs_sel_pirb), i_sw_data,
                           o_periph_irq_flags_b);
   assign base_option = pick(i_sw_we && (i_sw_sel == rcs_pkg::rcs_sel_option), i_sw_data,
                             o_option_reg);
   assign base_dira = pick(i_sw_we && (i_sw_sel == rcs_pkg::rcs_sel_dira), i_sw_data,
                           {2'h0, o_direction_reg_a});
   assign base_page = pick(i_sw_we && (i_sw_sel == rcs_pkg::rcs_sel_page), i_sw_data,
                           {3'h0, o_program_page_latch});

   ////////////////////////////////////////////////////////////////////////////////
   // next register values
   wire logic next_to;
   wire logic next_pd;
   wire logic [2:0] next_bank;
   wire logic [7:0] next_status;
   wire logic next_por_n;
   wire logic next_bor_n;
   wire logic [7:0] next_irq_control_reg;
   wire logic [7:0] next_pira;
   wire logic [7:0] next_pirb;
   wire logic [7:0] next_option;
   wire logic [5:0] next_dira;
   wire logic [4:0] next_page;
   wire logic [PC_WIDTH-1:0] sel_pc;
   wire logic sel_load;

   assign next_to = (is_por || is_bor || is_master_clear_pin_n_sleep ||
                     apply_cause == rcs_pkg::rcs_cause_irq_wake) ? 1'b1 : // R1 R4 R5
                    (is_wdt_reset || apply_cause == rcs_pkg::rcs_cause_wdt_wake) ? 1'b0 : // R7
                    base_status[`RCS_ST_TO]; // R3
   assign next_pd = (is_por || is_bor || is_wdt_reset) ? 1'b1 : // R2 R7
                    (is_master_clear_pin_n_sleep || is_wake) ? 1'b0 : // R4 R5 R7
                    base_status[`RCS_ST_PD]; // R3
   assign next_bank = is_full_reset ? `RCS_BANK_RESET :
                      base_status[`RCS_ST_BANK_HI:`RCS_ST_BANK_LO]; // R3 R4
   assign next_status = {next_bank, next_to, next_pd, base_status[2:0]}; // R5
   assign next_por_n = is_por ? 1'b0 : base_power_control_reg[`RCS_POWER_CONTROL_REG_POR]; // R8
   assign next_bor_n = is_bor ? 1'b0 : base_power_control_reg[`RCS_POWER_CONTROL_REG_BOR]; // R8
   assign next_irq_control_reg = is_full_reset ? (base_irq_control_reg & `RCS_IRQ_CONTROL_REG_KEEP) : // R9
                        is_wake ? (base_irq_control_reg | i_wake_irq_flags) : base_irq_control_reg; // R10
   // reserved flag bits come back cleared from every reset
   assign next_pira = is_full_reset ? `RCS_PIRA_RESET : // R11
                      is_wake ? (base_pira | i_wake_periph_flags_a) : base_pira; // R10
   assign next_pirb = is_full_reset ? `RCS_PIRB_RESET : // R11
                      is_wake ? (base_pirb | i_wake_periph_flags_b) : base_pirb; // R10
   assign next_option = is_full_reset ? `RCS_OPTION_RESET : base_option; // R9
   assign next_dira = is_full_reset ? `RCS_DIRA_RESET : base_dira[5:0]; // R9
   assign next_page = is_full_reset ? `RCS_PAGE_RESET : base_page[4:0]; // R9

   rcs_pc_sel #(
      .PC_WIDTH(PC_WIDTH)
   ) u_pc_sel (
      .i_cause(apply_cause),
      .i_pc(i_pc),
      .i_global_irq_enable(o_irq_control_reg[`RCS_GIE_BIT]), // R6
      .o_next_pc(sel_pc),
      .o_load(sel_load)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // registers; i_rst stands for a power-on with defined flag values
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_status <= `RCS_STATUS_RESET;
         o_power_control_reg <= `RCS_POWER_CONTROL_REG_RESET;
         o_irq_control_reg <= 8'h00;
         o_periph_irq_flags_a <= `RCS_PIRA_RESET;
         o_periph_irq_flags_b <= `RCS_PIRB_RESET;
         o_option_reg <= `RCS_OPTION_RESET;
         o_direction_reg_a <= `RCS_DIRA_RESET;
         o_program_page_latch <= `RCS_PAGE_RESET;
      end else begin
         o_status <= next_status;
         o_power_control_reg <= {next_por_n, next_bor_n};
         o_irq_control_reg <= next_irq_control_reg;
         o_periph_irq_flags_a <= next_pira;
         o_periph_irq_flags_b <= next_pirb;
         o_option_reg <= next_option;
         o_direction_reg_a <= next_dira;
         o_program_page_latch <= next_page;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_pc <= PC_WIDTH'(`RCS_PC_RESET);
         o_pc_load <= 1'b0;
         o_cause <= rcs_pkg::rcs_cause_por;
         o_cause_valid <= 1'b0;
         o_in_reset <= 1'b0;
      end else begin
         o_pc <= sel_load ? sel_pc : o_pc; // R14
         o_pc_load <= sel_load;
         o_cause <= sel_load ? apply_cause : o_cause; // R14
         o_cause_valid <= sel_load;
         o_in_reset <= (next_state == rcs_pkg::rcs_st_hold);
      end
   end
endmodule

// ===== test/rcs_checker.sv
// assertions on the ports of the reset cause block
`timescale 1ns/100ps
module rcs_checker #(
   parameter int PC_WIDTH = 13
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [PC_WIDTH-1:0] i_pc,
   input wire logic [7:0] i_wake_irq_flags,
   input wire logic [7:0] o_status,
   input wire logic [1:0] o_power_control_reg,
   input wire logic [7:0] o_irq_control_reg,
   input wire logic [7:0] o_option_reg,
   input wire logic [4:0] o_program_page_latch,
   input wire logic [PC_WIDTH-1:0] o_pc,
   input wire logic o_pc_load,
   input wire rcs_pkg::rcs_cause_type o_cause,
   input wire logic o_cause_valid
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   wire ev_por = o_cause_valid && o_cause == rcs_pkg::rcs_cause_por;
   wire ev_bor = o_cause_valid && o_cause == rcs_pkg::rcs_cause_bor;
   wire ev_wrst = o_cause_valid && o_cause == rcs_pkg::rcs_cause_wdt_reset;
   wire ev_mrun = o_cause_valid && o_cause == rcs_pkg::rcs_cause_master_clear_pin_n_run;
   wire ev_mslp = o_cause_valid && o_cause == rcs_pkg::rcs_cause_master_clear_pin_n_sleep;
   wire ev_wwake = o_cause_valid && o_cause == rcs_pkg::rcs_cause_wdt_wake;
   wire ev_iwake = o_cause_valid && o_cause == rcs_pkg::rcs_cause_irq_wake;
   ////////////////////////////////////////////////////////////////
   a_por_flags: assert property (ev_por |-> o_status[4:3] == 2'h3 && !o_power_control_reg[1])
      else $error("power-on flags wrong");
   a_bor_flag: assert property (ev_bor |-> o_status[7:3] == 5'h03
      && o_power_control_reg == {$past(o_power_control_reg[1]), 1'b0}) else $error("brown-out flags wrong");
   a_full_values: assert property (ev_por || ev_bor |-> o_option_reg == 8'hFF
      && o_program_page_latch == 5'h00 && o_irq_control_reg == {7'h00, $past(o_irq_control_reg[0])})
      else $error("full reset values wrong");
   a_master_clear_pin_n_run: assert property (ev_mrun |-> o_status == {3'h0, $past(o_status[4:0])}
      && o_pc == 0 && $stable(o_power_control_reg)) else $error("master-clear run values wrong");
   a_master_clear_pin_n_sleep: assert property (ev_mslp |-> o_status[7:3] == 5'h02 && o_pc == 0)
      else $error("master-clear sleep values wrong");
   a_wdt_reset: assert property (ev_wrst |-> o_status[7:3] == 5'h01 && o_pc == 0)
      else $error("watchdog reset values wrong");
   a_wdt_wake: assert property (ev_wwake |-> o_status[4:3] == 2'h0 && o_pc == $past(i_pc) + 1'b1)
      else $error("watchdog wake values wrong");
   a_irq_wake: assert property (ev_iwake |-> o_status[4:3] == 2'h2
      && o_pc == ($past(o_irq_control_reg[7]) ? 13'h0004 : $past(i_pc) + 1'b1))
      else $error("interrupt wake values wrong");
   a_wake_flags: assert property (ev_iwake |-> o_irq_control_reg
      == ($past(o_irq_control_reg) | $past(i_wake_irq_flags))) else $error("wake flags not recorded");
   a_wake_keep: assert property (ev_wwake || ev_iwake |-> $stable(o_option_reg)
      && o_status[7:5] == $past(o_status[7:5])) else $error("wake disturbed registers");
   a_load_pair: assert property (o_pc_load == o_cause_valid)
      else $error("load and cause pulses apart");
   c_iwake: cover property (ev_iwake);
   c_mslp: cover property (ev_mslp);
   c_bor: cover property (ev_bor);
endmodule
bind rcs_top rcs_checker #(.PC_WIDTH(PC_WIDTH)) u_rcs_checker (.i_clock(i_clock), .i_rst(i_rst),
   .i_pc(i_pc), .i_wake_irq_flags(i_wake_irq_flags), .o_status(o_status),
   .o_power_control_reg(o_power_control_reg), .o_irq_control_reg(o_irq_control_reg),
   .o_option_reg(o_option_reg), .o_program_page_latch(o_program_page_latch), .o_pc(o_pc),
   .o_pc_load(o_pc_load), .o_cause(o_cause), .o_cause_valid(o_cause_valid));

// ===== test/tb.sv
// self-checking bench for the reset cause block
`timescale 1ns/100ps
module tb;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_por_req = 1'b0, i_bor_req = 1'b0, i_watchdog_timeout = 1'b0;
   logic i_brownout_circuit_enable = 1'b1, i_master_clear_pin_n = 1'b1;
   logic i_sleeping = 1'b0, i_wake_irq = 1'b0, i_sw_we = 1'b0;
   logic [7:0] i_wake_irq_flags = 8'h00, i_wake_periph_flags_a = 8'h00;
   logic [7:0] i_wake_periph_flags_b = 8'h00, i_sw_data = 8'h00;
   logic [12:0] i_pc = 13'h0000;
   rcs_pkg::rcs_sel_type i_sw_sel = rcs_pkg::rcs_sel_status;
   logic [7:0] o_status, o_irq_control_reg, o_periph_irq_flags_a, o_periph_irq_flags_b, o_option_reg;
   logic [1:0] o_power_control_reg;
   logic [5:0] o_direction_reg_a;
   logic [4:0] o_program_page_latch;
   logic [12:0] o_pc;
   logic o_pc_load, o_cause_valid, o_in_reset;
   rcs_pkg::rcs_cause_type o_cause;
   int n_fail = 0;
   int n_checks = 0;
   rcs_top #(.PC_WIDTH(13)) u_rcs_top (.i_clock(i_clock), .i_rst(i_rst), .i_por_req(i_por_req),
      .i_bor_req(i_bor_req), .i_brownout_circuit_enable(i_brownout_circuit_enable),
      .i_master_clear_pin_n(i_master_clear_pin_n), .i_watchdog_timeout(i_watchdog_timeout),
      .i_sleeping(i_sleeping), .i_wake_irq(i_wake_irq), .i_wake_irq_flags(i_wake_irq_flags),
      .i_wake_periph_flags_a(i_wake_periph_flags_a), .i_wake_periph_flags_b(i_wake_periph_flags_b),
      .i_pc(i_pc), .i_sw_we(i_sw_we), .i_sw_sel(i_sw_sel), .i_sw_data(i_sw_data),
      .o_status(o_status), .o_power_control_reg(o_power_control_reg),
      .o_irq_control_reg(o_irq_control_reg), .o_periph_irq_flags_a(o_periph_irq_flags_a),
      .o_periph_irq_flags_b(o_periph_irq_flags_b), .o_option_reg(o_option_reg),
      .o_direction_reg_a(o_direction_reg_a), .o_program_page_latch(o_program_page_latch),
      .o_pc(o_pc), .o_pc_load(o_pc_load), .o_cause(o_cause), .o_cause_valid(o_cause_valid),
      .o_in_reset(o_in_reset));
   always #25 i_clock = ~i_clock;
   ////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_core(input logic [7:0] st, input logic [1:0] pcr, input logic [12:0] pc,
                           input rcs_pkg::rcs_cause_type c);
      chk(o_status, st);
      chk(o_power_control_reg, pcr);
      chk(o_pc, pc);
      chk(o_cause, c);
   endtask
   task automatic wr(input rcs_pkg::rcs_sel_type sel, input logic [7:0] d);
      @(negedge i_clock);
      i_sw_we = 1'b1;
      i_sw_sel = sel;
      i_sw_data = d;
      @(negedge i_clock);
      i_sw_we = 1'b0;
   endtask
   // req bits: power-on, brown-out, watchdog, master-clear
   task automatic do_reset(input logic [3:0] req, input logic slp);
      int n;
      @(negedge i_clock);
      {i_por_req, i_bor_req, i_watchdog_timeout} = req[3:1];
      i_master_clear_pin_n = ~req[0];
      i_sleeping = slp;
      n = 0;
      while (o_in_reset !== 1'b1 && n < 8) begin
         @(negedge i_clock);
         n++;
      end
      if (n == 8) begin
         n_fail++;
         test_done();
      end
      {i_por_req, i_bor_req, i_watchdog_timeout, i_sleeping} = 4'h0;
      i_master_clear_pin_n = 1'b1;
      @(posedge i_clock);
      #1;
      chk(o_cause_valid, 1'b1);
      chk(o_pc_load, 1'b1);
   endtask
   // wake is a one-cycle pulse, else it would repeat every cycle
   task automatic do_wake(input logic wdt, input logic [12:0] pc);
      @(negedge i_clock);
      i_sleeping = 1'b1;
      i_watchdog_timeout = wdt;
      i_wake_irq = ~wdt;
      i_pc = pc;
      @(posedge i_clock);
      #1;
      chk(o_cause_valid, 1'b1);
      @(negedge i_clock);
      {i_sleeping, i_watchdog_timeout, i_wake_irq} = 3'h0;
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset_vals();
      chk_core(8'h18, 2'h1, 13'h0000, rcs_pkg::rcs_cause_por);
      chk(o_option_reg, 8'hFF);
      chk(o_direction_reg_a, 6'h3F);
      chk(o_program_page_latch, 5'h00);
      chk(o_irq_control_reg, 8'h00);
      $display("test reset values done");
   endtask
   task automatic t_master_clear_pin_n();
      wr(rcs_pkg::rcs_sel_power_control_reg, 8'h03);
      wr(rcs_pkg::rcs_sel_status, 8'hE7);
      do_reset(4'h1, 1'b0);
      chk_core(8'h07, 2'h3, 13'h0000, rcs_pkg::rcs_cause_master_clear_pin_n_run);
      wr(rcs_pkg::rcs_sel_status, 8'hE7);
      do_reset(4'h1, 1'b1);
      chk_core(8'h17, 2'h3, 13'h0000, rcs_pkg::rcs_cause_master_clear_pin_n_sleep);
      $display("test master clear done");
   endtask
   task automatic t_wdt();
      wr(rcs_pkg::rcs_sel_status, 8'hF2);
      do_reset(4'h2, 1'b0);
      chk_core(8'h0A, 2'h3, 13'h0000, rcs_pkg::rcs_cause_wdt_reset);
      wr(rcs_pkg::rcs_sel_status, 8'hF5);
      wr(rcs_pkg::rcs_sel_option, 8'h5A);
      do_wake(1'b1, 13'h1FFF);
      chk_core(8'hE5, 2'h3, 13'h0000, rcs_pkg::rcs_cause_wdt_wake);
      chk(o_option_reg, 8'h5A);
      $display("test watchdog done");
   endtask
   task automatic t_irq_wake();
      wr(rcs_pkg::rcs_sel_irq_control_reg, 8'h01);
      wr(rcs_pkg::rcs_sel_status, 8'hE0);
      i_wake_irq_flags = 8'h02;
      i_wake_periph_flags_a = 8'h10;
      i_wake_periph_flags_b = 8'h01;
      do_wake(1'b0, 13'h0040);
      chk_core(8'hF0, 2'h3, 13'h0041, rcs_pkg::rcs_cause_irq_wake);
      chk(o_irq_control_reg, 8'h03);
      chk(o_periph_irq_flags_a, 8'h10);
      chk(o_periph_irq_flags_b, 8'h01);
      wr(rcs_pkg::rcs_sel_irq_control_reg, 8'h80);
      do_wake(1'b0, 13'h0040);
      chk(o_pc, 13'h0004);
      chk(o_irq_control_reg, 8'h82);
      $display("test interrupt wake done");
   endtask
   task automatic t_priority();
      wr(rcs_pkg::rcs_sel_power_control_reg, 8'h03);
      wr(rcs_pkg::rcs_sel_page, 8'h1F);
      do_reset(4'hF, 1'b0);
      chk_core(8'h18, 2'h1, 13'h0000, rcs_pkg::rcs_cause_por);
      chk(o_program_page_latch, 5'h00);
      wr(rcs_pkg::rcs_sel_power_control_reg, 8'h03);
      wr(rcs_pkg::rcs_sel_option, 8'h5A);
      do_reset(4'h7, 1'b0);
      chk_core(8'h18, 2'h2, 13'h0000, rcs_pkg::rcs_cause_bor);
      chk(o_option_reg, 8'hFF);
      do_reset(4'h3, 1'b0);
      chk_core(8'h08, 2'h2, 13'h0000, rcs_pkg::rcs_cause_wdt_reset);
      $display("test priority done");
   endtask
   task automatic t_refused();
      @(negedge i_clock);
      i_brownout_circuit_enable = 1'b0;
      i_bor_req = 1'b1;
      i_wake_irq = 1'b1;
      @(posedge i_clock);
      #1;
      chk(o_cause_valid, 1'b0);
      @(negedge i_clock);
      chk(o_in_reset, 1'b0);
      {i_bor_req, i_wake_irq, i_brownout_circuit_enable} = 3'h1;
      $display("test refused requests done");
   endtask
   initial begin
      repeat (12) @(posedge i_clock);
      @(negedge i_clock);
      i_rst = 1'b0;
      t_reset_vals();
      t_master_clear_pin_n();
      t_wdt();
      t_irq_wake();
      t_priority();
      t_refused();
      test_done();
   end
endmodule
